// file: j1939_consts.svh
`ifndef J1939_CONSTS_SVH
`define J1939_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave.
`define OFS_NODE_ADDR 8'h00
`define OFS_STATUS 8'h04
`define OFS_TX_ID 8'h08
`define OFS_TX_OUT 8'h0c
`define OFS_RX_DATA 8'h10
`define OFS_RX_INFO 8'h14
`define OFS_NAME_LO 8'h18
`define OFS_NAME_HI 8'h1c
`define OFS_PEER_LO 8'h20
`define OFS_PEER_HI 8'h24

// Special node addresses and the first global PDU format value.
`define ADDR_NULL 8'hfe
`define ADDR_GLOBAL 8'hff
`define PF_GLOBAL_MIN 8'hf0
`define RST_NODE_ADDR 8'hfe

// Identifier field positions.
`define ID_SA_LSB 0
`define ID_PS_LSB 8
`define ID_PF_LSB 16
`define ID_DP_BIT 24
`define ID_EDP_BIT 25
`define ID_PRIO_LSB 26
`define NAME_ARB_BIT 63

// Status register bit positions.
`define ST_TX_ERR 0
`define ST_TX_BUSY 1
`define ST_RX_EMPTY 2
`define ST_NAME_WINS 3
`define ST_OWN_ARB 4
`define ST_PEER_ARB 5
`define ST_COUNT_LSB 8

// Receive buffer depth.
`define FIFO_DEPTH 16

`endif

// file: j1939_pkg.sv
package j1939_pkg;

    typedef logic [28:0] can_id_t;

    typedef struct packed {
        logic [2:0] prio;
        logic edp;
        logic dp;
        logic [7:0] pf;
        logic [7:0] ps;
        logic [7:0] sa;
    } id_fields_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_WR_WAIT = 2'b10
    } bus_state_e;

endpackage : j1939_pkg

// file: j1939_id_address_filter.sv
`timescale 1ns/100ps
`include "j1939_consts.svh"

module j1939_fifo #(
    parameter int WIDTH = 29,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Filling side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Draining side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic push;
    logic pop;

    assign o_in_ready = (count_reg != CW'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem_reg[rd_ptr_reg];
    assign o_count = count_reg;
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                                                            : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                                                            : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : j1939_fifo

//Contract
//- Frames use 29-bit extended identifiers
//- Source address is identifier bits 7..0
//- PGN is identifier bits 25..8
//- PF below 0xF0 is destination-specific
//- Global frames: PS is group extension
//- Specific frames: PS is destination address
//- EDP sent as zero, DP free
//- Address 254 is null address
//- Address 255 is global destination
//- Own address reads 254 until assigned
//- Assigned address: accept global or own only
//- Null or global address: pass everything
//- No address: send only valid source
//- Valid address replaces outgoing source address
//- No address, invalid source: reject, error
//- Lower 64-bit name has higher priority
//- Name bit 63 set ranks lower
module j1939_id_address_filter
    import j1939_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    // AHB-Lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic O_HREADYOUT,
    output logic [31:0] O_HRDATA,
    output logic O_HRESP,
    // Received frames from the CAN controller
    input wire logic I_RX_VALID,
    input wire logic [28:0] I_RX_ID,
    output logic O_RX_READY,
    // Frames to the CAN controller
    output logic O_TX_VALID,
    output logic [28:0] O_TX_ID,
    input wire logic I_TX_READY
);
    localparam int CW = $clog2(FIFO_DEPTH+1);

    function automatic logic addr_valid(input logic [7:0] a);
        return (a != `ADDR_NULL) && (a != `ADDR_GLOBAL);
    endfunction : addr_valid

    function automatic logic pf_global(input logic [7:0] pf);
        return pf >= `PF_GLOBAL_MIN;
    endfunction : pf_global

    function automatic logic [17:0] pgn_of(input can_id_t id);
        id_fields_s f;
        f = id_fields_s'(id);
        // A specific frame's PS is an address, not part of the PGN.
        return {f.edp, f.dp, f.pf, pf_global(f.pf) ? f.ps : 8'h00};
    endfunction : pgn_of

    function automatic logic rx_pass(input can_id_t id, input logic [7:0] own);
        id_fields_s f;
        f = id_fields_s'(id);
        if (!addr_valid(own)) begin
            return 1'b1;
        end
        return pf_global(f.pf) || (f.ps == `ADDR_GLOBAL) || (f.ps == own);
    endfunction : rx_pass

    bus_state_e bus_state_reg;
    logic [7:0] wr_addr_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic [7:0] node_addr_reg;
    logic addr_written_reg;
    logic [31:0] name_lo_reg;
    logic [31:0] name_hi_reg;
    logic [31:0] peer_lo_reg;
    logic [31:0] peer_hi_reg;
    logic tx_err_reg;
    logic tx_valid_reg;
    can_id_t tx_id_reg;
    logic cap_valid_reg;
    can_id_t cap_id_reg;
    logic rx_ready_reg;

    logic addr_ok;
    logic wr_en;
    logic wr_tx;
    logic tx_reject;
    logic name_wins;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    can_id_t fifo_out_data;
    logic [CW-1:0] fifo_count;
    logic cap_accept;
    logic cap_done;
    logic cap_next;
    id_fields_s tx_f;
    id_fields_s head_f;
    logic [31:0] status_word;
    logic [31:0] rd_mux;

    assign addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign wr_en = (bus_state_reg == BUS_WR_WAIT);
    assign wr_tx = wr_en && (wr_addr_reg == `OFS_TX_ID) && !tx_valid_reg;
    assign tx_f = id_fields_s'(I_HWDATA[28:0]);
    assign tx_reject = !addr_valid(node_addr_reg) && !addr_valid(tx_f.sa);
    // Bit 63 is the top bit, so a plain compare ranks capable names lower.
    assign name_wins = {name_hi_reg, name_lo_reg} < {peer_hi_reg, peer_lo_reg};
    assign head_f = id_fields_s'(fifo_out_data);

    always_comb begin
        status_word = '0;
        status_word[`ST_TX_ERR] = tx_err_reg;
        status_word[`ST_TX_BUSY] = tx_valid_reg;
        status_word[`ST_RX_EMPTY] = !fifo_out_valid;
        status_word[`ST_NAME_WINS] = name_wins;
        status_word[`ST_OWN_ARB] = name_hi_reg[`NAME_ARB_BIT-32];
        status_word[`ST_PEER_ARB] = peer_hi_reg[`NAME_ARB_BIT-32];
        status_word[`ST_COUNT_LSB +: CW] = fifo_count;
    end

    always_comb begin
        case (I_HADDR[7:0])
            `OFS_NODE_ADDR: rd_mux = {24'h000000, node_addr_reg};
            `OFS_STATUS: rd_mux = status_word;
            `OFS_TX_OUT: rd_mux = {3'h0, tx_id_reg};
            `OFS_RX_DATA: rd_mux = {3'h0, fifo_out_data};
            `OFS_RX_INFO: rd_mux = {1'b0, head_f.prio, 1'b0,
                                    pf_global(head_f.pf), head_f.ps,
                                    pgn_of(fifo_out_data)};
            `OFS_NAME_LO: rd_mux = name_lo_reg;
            `OFS_NAME_HI: rd_mux = name_hi_reg;
            `OFS_PEER_LO: rd_mux = peer_lo_reg;
            `OFS_PEER_HI: rd_mux = peer_hi_reg;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Writes take one wait state so a following read sees the new value.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            bus_state_reg <= BUS_IDLE;
            wr_addr_reg <= 8'h00;
            hreadyout_reg <= 1'b1;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (addr_ok && I_HWRITE) begin
                        bus_state_reg <= BUS_WR_WAIT;
                        wr_addr_reg <= I_HADDR[7:0];
                        hreadyout_reg <= 1'b0;
                    end
                end
                BUS_WR_WAIT: begin
                    bus_state_reg <= BUS_IDLE;
                    hreadyout_reg <= 1'b1;
                end
                default: begin
                    bus_state_reg <= BUS_IDLE;
                    hreadyout_reg <= 1'b1;
                end
            endcase
        end
    end

    // Reading the receive data register pops the buffer head.
    assign fifo_pop = addr_ok && !I_HWRITE && hreadyout_reg &&
                      (I_HADDR[7:0] == `OFS_RX_DATA);

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            hrdata_reg <= 32'h00000000;
        end else if (addr_ok && !I_HWRITE && hreadyout_reg) begin
            hrdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            node_addr_reg <= `RST_NODE_ADDR;
            addr_written_reg <= 1'b0;
            name_lo_reg <= 32'h00000000;
            name_hi_reg <= 32'h00000000;
            peer_lo_reg <= 32'h00000000;
            peer_hi_reg <= 32'h00000000;
        end else if (wr_en) begin
            case (wr_addr_reg)
                `OFS_NODE_ADDR: begin
                    node_addr_reg <= I_HWDATA[7:0];
                    addr_written_reg <= 1'b1;
                end
                `OFS_NAME_LO: name_lo_reg <= I_HWDATA;
                `OFS_NAME_HI: name_hi_reg <= I_HWDATA;
                `OFS_PEER_LO: peer_lo_reg <= I_HWDATA;
                `OFS_PEER_HI: peer_hi_reg <= I_HWDATA;
                default: begin
                end
            endcase
        end
    end

    // A write while a frame is still pending is dropped.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            tx_valid_reg <= 1'b0;
            tx_id_reg <= '0;
        end else if (wr_tx && !tx_reject) begin
            tx_valid_reg <= 1'b1;
            tx_id_reg[28:26] <= tx_f.prio;
            tx_id_reg[`ID_EDP_BIT] <= 1'b0;
            tx_id_reg[`ID_DP_BIT] <= tx_f.dp;
            tx_id_reg[23:8] <= {tx_f.pf, tx_f.ps};
            if (addr_valid(node_addr_reg)) begin
                tx_id_reg[7:0] <= node_addr_reg;
            end else begin
                tx_id_reg[7:0] <= tx_f.sa;
            end
        end else if (tx_valid_reg && I_TX_READY) begin
            tx_valid_reg <= 1'b0;
        end
    end

    // Error is write-one-to-clear; a new error in the same cycle wins.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            tx_err_reg <= 1'b0;
        end else if (wr_tx && tx_reject) begin
            tx_err_reg <= 1'b1;
        end else if (wr_en && (wr_addr_reg == `OFS_STATUS) &&
                     I_HWDATA[`ST_TX_ERR]) begin
            tx_err_reg <= 1'b0;
        end
    end

    assign cap_accept = rx_pass(cap_id_reg, node_addr_reg);
    assign fifo_in_valid = cap_valid_reg && cap_accept;
    assign cap_done = cap_valid_reg && (!cap_accept || fifo_in_ready);
    assign cap_next = cap_valid_reg ? !cap_done : (I_RX_VALID && rx_ready_reg);

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            cap_valid_reg <= 1'b0;
            cap_id_reg <= '0;
            rx_ready_reg <= 1'b1;
        end else begin
            cap_valid_reg <= cap_next;
            rx_ready_reg <= !cap_next;
            if (!cap_valid_reg && I_RX_VALID && rx_ready_reg) begin
                cap_id_reg <= I_RX_ID;
            end
        end
    end

    j1939_fifo #(
        .WIDTH(29),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(cap_id_reg),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out_data),
        .o_count(fifo_count)
    );

    assign O_HREADYOUT = hreadyout_reg;
    assign O_HRDATA = hrdata_reg;
    assign O_HRESP = 1'b0;
    assign O_RX_READY = rx_ready_reg;
    assign O_TX_VALID = tx_valid_reg;
    assign O_TX_ID = tx_id_reg;

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RST);

    sequence s_wr_addr;
        addr_ok && I_HWRITE && (bus_state_reg == BUS_IDLE);
    endsequence
    sequence s_wr_wait;
        !O_HREADYOUT ##1 O_HREADYOUT;
    endsequence

    a_write_wait_state: assert property (s_wr_addr |=> s_wr_wait)
        else $error("write did not take exactly one wait state");
    a_sa_substitute: assert property (
        wr_tx && !tx_reject && addr_valid(node_addr_reg)
        |=> O_TX_VALID && (O_TX_ID[7:0] == $past(node_addr_reg)))
        else $error("claimed address not placed in source field");
    a_sa_keep: assert property (
        wr_tx && !addr_valid(node_addr_reg) && addr_valid(I_HWDATA[7:0])
        |=> O_TX_VALID && (O_TX_ID[7:0] == $past(I_HWDATA[7:0])))
        else $error("frame source address altered without own address");
    a_tx_reject: assert property (
        wr_tx && tx_reject |=> tx_err_reg && !O_TX_VALID)
        else $error("invalid source frame not rejected");
    a_edp_zero: assert property (O_TX_VALID |-> !O_TX_ID[`ID_EDP_BIT])
        else $error("extended data page bit sent as one");
    a_rx_foreign_drop: assert property (
        cap_valid_reg && addr_valid(node_addr_reg) &&
        !pf_global(cap_id_reg[23:16]) &&
        (cap_id_reg[15:8] != `ADDR_GLOBAL) &&
        (cap_id_reg[15:8] != node_addr_reg)
        |-> !fifo_in_valid ##1 !cap_valid_reg)
        else $error("frame for another node was accepted");
    a_rx_null_pass: assert property (
        cap_valid_reg && !addr_valid(node_addr_reg) && fifo_in_ready
        |-> fifo_in_valid ##1 (fifo_count != '0))
        else $error("frame dropped while holding no address");
    a_addr_unset: assert property (
        !addr_written_reg |-> node_addr_reg == `ADDR_NULL)
        else $error("own address not null before assignment");
    a_name_arb_rank: assert property (
        name_hi_reg[31] && !peer_hi_reg[31] |-> !name_wins)
        else $error("arbitrary-capable name outranked a fixed name");
    a_rx_backpressure: assert property (
        fifo_in_valid && !fifo_in_ready |=> cap_valid_reg && !O_RX_READY)
        else $error("full buffer did not stall the receive side");
endmodule : j1939_id_address_filter

// file: can_peer_model.sv
`timescale 1ns/100ps
module can_peer_model (
    // Clock and stall control
    input wire logic i_clk,
    input wire logic i_slow,
    // Frames towards the block
    output logic o_rx_valid,
    output logic [28:0] o_rx_id,
    input wire logic i_rx_ready,
    // Frames from the block
    input wire logic i_tx_valid,
    input wire logic [28:0] i_tx_id,
    output logic o_tx_ready
);
    logic [28:0] sent_q[$];
    logic [1:0] cnt = 2'h0;
    initial begin
        o_rx_valid = 1'b0;
        o_rx_id = 29'h0;
        o_tx_ready = 1'b0;
    end
    // A frame is held until taken or for at most 100 cycles; afterwards the id lines show its inverse.
    // Each frame starts one edge after the call, so back-to-back frames
    // never assign the valid line twice at the same edge.
    task automatic send(input logic [28:0] id, output bit ok);
        int n;
        n = 0;
        @(posedge i_clk);
        o_rx_valid <= 1'b1;
        o_rx_id <= id;
        do begin
            @(negedge i_clk);
            n++;
        end while (i_rx_ready !== 1'b1 && n < 100);
        ok = (i_rx_ready === 1'b1);
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_id <= ~id;
    endtask : send
    // When slow, the controller accepts only one cycle in four.
    always @(posedge i_clk) begin
        cnt <= cnt + 2'h1;
        o_tx_ready <= !i_slow || cnt == 2'h3;
        if (i_tx_valid === 1'b1 && o_tx_ready) begin
            sent_q.push_back(i_tx_id);
        end
    end
endmodule : can_peer_model

// file: j1939_id_address_filter_tb_top.sv
`timescale 1ns/100ps
`include "j1939_consts.svh"
module j1939_id_address_filter_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, slow = 1'b0;
    logic rx_valid, rx_ready, tx_valid, tx_ready;
    logic [31:0] hrdata, rd;
    logic [28:0] rx_id, tx_id, r;
    logic [63:0] a, b;
    logic [28:0] exp_q[$];
    logic [7:0] own_t[5] = '{8'hfe, 8'hff, 8'h42, 8'h00, 8'hfd};
    logic [7:0] sa_t[4] = '{8'h00, 8'hfd, 8'hfe, 8'hff};
    int fail_count = 0;
    int tests_run = 0;
    int seed = 27;
    always #5 clk = ~clk;
    j1939_id_address_filter uut (.I_REF_CLK(clk), .I_RST(rst),
        .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hreadyout), .O_HREADYOUT(hreadyout), .O_HRDATA(hrdata),
        .O_HRESP(hresp), .I_RX_VALID(rx_valid), .I_RX_ID(rx_id),
        .O_RX_READY(rx_ready), .O_TX_VALID(tx_valid), .O_TX_ID(tx_id),
        .I_TX_READY(tx_ready));
    can_peer_model peer (.i_clk(clk), .i_slow(slow), .o_rx_valid(rx_valid),
        .o_rx_id(rx_id), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
        .i_tx_id(tx_id), .o_tx_ready(tx_ready));
    task automatic results();
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    task automatic check(input string nm, input logic [63:0] e,
                         input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : check
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (hreadyout !== 1'b1) begin
            fail_count++;
            results();
        end
        @(posedge clk);
    endtask : wait_ready
    task automatic bus(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
    endtask : bus
    task automatic tx(input logic [28:0] id, input logic [7:0] own);
        logic [28:0] e;
        int n0, n;
        n0 = peer.sent_q.size();
        n = 0;
        e = id;
        e[25] = 1'b0;
        if (own <= 8'hfd) e[7:0] = own;
        bus(1'b1, `OFS_TX_ID, {3'h0, id});
        while (peer.sent_q.size() == n0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (own > 8'hfd && id[7:0] > 8'hfd) begin
            check("tx dropped", n0, peer.sent_q.size());
            bus(1'b0, `OFS_STATUS, 32'h0);
            check("tx_err", 1'b1, rd[0]);
            bus(1'b1, `OFS_STATUS, 32'h1);
            bus(1'b0, `OFS_STATUS, 32'h0);
            check("tx_err clear", 1'b0, rd[0]);
        end else begin
            check("tx id", e, peer.sent_q.pop_back());
            bus(1'b0, `OFS_TX_OUT, 32'h0);
            check("tx out", e, rd[28:0]);
        end
    endtask : tx
    task automatic rx(input logic [28:0] id, input logic [7:0] own);
        bit ok;
        peer.send(id, ok);
        check("rx taken", 1'b1, ok);
        if (own >= 8'hfe || id[23:16] >= 8'hf0 || id[15:8] == 8'hff ||
            id[15:8] == own) begin
            exp_q.push_back(id);
        end
    endtask : rx
    task automatic drain();
        logic [28:0] e;
        int n;
        repeat (3) @(posedge clk);
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            bus(1'b0, `OFS_STATUS, 32'h0);
            // A frame beyond the buffer's depth waits in the capture stage.
            n = exp_q.size() + 1;
            if (n > `FIFO_DEPTH) n = `FIFO_DEPTH;
            check("rx count", n, rd[12:8]);
            bus(1'b0, `OFS_RX_INFO, 32'h0);
            check("rx pgn", {e[25:16], e[23:16] >= 8'hf0 ? e[15:8] : 8'h0},
                  rd[17:0]);
            check("rx ps", e[15:8], rd[25:18]);
            check("rx global", e[23:16] >= 8'hf0, rd[26]);
            check("rx prio", e[28:26], rd[30:28]);
            bus(1'b0, `OFS_RX_DATA, 32'h0);
            check("rx id", e, rd[28:0]);
        end
        bus(1'b0, `OFS_STATUS, 32'h0);
        check("rx empty", 1'b1, rd[2]);
    endtask : drain
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, `OFS_NODE_ADDR, 32'h0);
        check("node addr", 8'hfe, rd[7:0]);
        check("hresp", 1'b0, hresp);
        bus(1'b1, 8'h30, 32'hffffffff);
        bus(1'b0, 8'h30, 32'h0);
        check("unmapped", 32'h0, rd);
        foreach (own_t[i]) begin
            bus(1'b1, `OFS_NODE_ADDR, {24'h0, own_t[i]});
            slow <= own_t[i][0];
            foreach (sa_t[j]) begin
                r = 29'($random(seed));
                r[7:0] = sa_t[j];
                tx(r, own_t[i]);
            end
        end
        foreach (own_t[i]) begin
            bus(1'b1, `OFS_NODE_ADDR, {24'h0, own_t[i]});
            for (int k = 0; k < 12; k++) begin
                r = 29'($random(seed));
                r[25] = 1'b0;
                if (k % 3 == 0) r[15:8] = own_t[i];
                if (k % 3 == 1) r[15:8] = 8'hff;
                if (k % 4 == 0) r[23:16] = 8'hef;
                if (k % 4 == 1) r[23:16] = 8'hf0;
                rx(r, own_t[i]);
            end
            drain();
        end
        // The buffer is filled and one more frame is held in the capture
        // stage, which must then hold back the controller.
        bus(1'b1, `OFS_NODE_ADDR, 32'hfe);
        repeat (`FIFO_DEPTH + 1) begin
            r = 29'($random(seed));
            r[25] = 1'b0;
            rx(r, 8'hfe);
        end
        repeat (8) begin
            @(negedge clk);
            check("rx full", 1'b0, rx_ready);
        end
        @(posedge clk);
        drain();
        for (int k = 0; k < 12; k++) begin
            a = {$random(seed), $random(seed)};
            b = {$random(seed), $random(seed)};
            if (k == 0) b = a;
            if (k == 1) b = a ^ 64'h1;
            if (k == 2) a[63] = ~b[63];
            bus(1'b1, `OFS_NAME_LO, a[31:0]);
            bus(1'b1, `OFS_NAME_HI, a[63:32]);
            bus(1'b1, `OFS_PEER_LO, b[31:0]);
            bus(1'b1, `OFS_PEER_HI, b[63:32]);
            bus(1'b0, `OFS_STATUS, 32'h0);
            check("name wins", a < b, rd[3]);
            check("own arb", a[63], rd[4]);
            check("peer arb", b[63], rd[5]);
        end
        results();
    end
endmodule : j1939_id_address_filter_tb_top
